// File: hw/ald_decoder.sv
`timescale 1ns/1ps

// Behaviour
// - decode word add, subtract, compare with immediate, short, sfr, pair forms
// - four unsigned multiply/divide ops after prefix 05, register in low bits
// - signed word multiply: 05 then 00111 and register pair code
// - sum of products: 07, 85, then an 8-bit repeat count
// - saturating sum of products: 07, 05, then the count byte
// - memory forms: low displacement third byte; direction bit picks destination
// - 16-bit displacement high byte arrives as fourth byte
// - eight byte ops over immediate, register, short, sfr, memory forms
// - low sfr window uses short-direct forms, decoded as short-direct
// - two short operands: first offset is source, second destination
module ald_decoder import ald_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  output logic byte_ready_out,
  output logic dec_valid_out,
  output ald_dec_t dec_out,
  output logic illegal_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ald_state_t s_q;
  ald_state_t s_d;
  logic [7:0] b;
  logic take;

  assign b = byte_in;
  assign take = byte_valid_in;
  assign byte_ready_out = 1'b1;
  assign dec_valid_out = s_q.valid;
  assign dec_out = s_q.dec;
  assign illegal_out = s_q.bad;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.bad = 1'b0;
    if (take) begin
      case (s_q.st)
        ST_B1: begin
          s_d.b1 = b;
          s_d.idx = 3'd1;
          s_d.dec = '0;
          s_d.dec.op = ald_op_t'({1'b0, b[2:0]});
          s_d.dec.flags_only = (b[2:0] == 3'd7);
          s_d.dec.form = FRM_NONE;
          s_d.st = ST_B2;
          s_d.need = 3'd2;
          s_d.pfx01 = 1'b0;
          if (b[7:3] == OP_B_IMM_A) begin
            s_d.dec.form = FRM_IMM;
          end else if (b[7:3] == OP_B_SADDR_IMM) begin
            s_d.dec.form = FRM_SADDR_IMM;
            s_d.need = 3'd3;
          end else if (b[7:3] == OP_B_RR) begin
            s_d.dec.form = FRM_REG;
          end else if (b[7:3] == OP_B_A_SADDR) begin
            s_d.dec.form = FRM_SADDR;
          end else if (b[7:3] == OP_B_SADDR2) begin
            s_d.dec.form = FRM_SADDR2;
            s_d.need = 3'd3;
          end else if (b[7:6] == 2'd0 && b[3:0] > 4'hc) begin
            s_d.dec.word = 1'b1;
            case (b[5:4])
              2'd0: s_d.dec.form = FRM_SADDR_IMM;
              2'd1: s_d.dec.form = FRM_SADDR;
              2'd2: s_d.dec.form = FRM_IMM;
              default: s_d.dec.form = FRM_SADDR2;
            endcase
            s_d.need = (b[5:4] == 2'd0) ? 3'd4 :
                       (b[5:4] == 2'd1) ? 3'd2 : 3'd3;
            s_d.dec.op = b[1] ? (b[0] ? ALD_WORD_COMPARE : ALD_WORD_SUBTRACT)
                              : ALD_WORD_ADD;
            s_d.dec.flags_only = (b[1:0] == 2'd3);
          end else if (b == OP_PFX_01 || b == OP_PFX_05 || b == OP_PFX_07)
          begin
            s_d.pfx01 = 1'b1;
          end else if (b[7:5] == OP_MEM_TOP) begin
            s_d.dec.form = FRM_MEM;
            s_d.dec.mod = b[4:0];
            s_d.need = (b[4:0] == MOD_BASED || b[4:0] == MOD_INDEXED) ?
                       3'd3 : 3'd2;
          end else begin
            s_d.bad = 1'b1;
            s_d.st = ST_B1;
          end
        end
        ST_B2: begin
          s_d.b2 = b;
          s_d.idx = 3'd2;
          s_d.st = ST_MORE;
          if (s_q.pfx01) begin
            if (s_q.b1 == OP_PFX_07) begin
              s_d.dec.is_mac = 1'b1;
              s_d.dec.form = FRM_MAC;
              s_d.dec.mac_sat = (b == OP_MACS_B2);
              s_d.need = 3'd3;
              if (b != OP_MAC_B2 && b != OP_MACS_B2) begin
                s_d.bad = 1'b1;
                s_d.st = ST_B1;
              end
            end else if (s_q.b1 == OP_PFX_05) begin
              s_d.dec.form = FRM_REG;
              s_d.dec.src_reg = b[2:0];
              s_d.st = ST_B1;
              s_d.valid = 1'b1;
              case (b[7:3])
                OP_UNSIGNED_BYTE_MULTIPLY_HI: s_d.dec.op = ALD_UNSIGNED_BYTE_MULTIPLY;
                OP_UNSIGNED_WORD_DIVIDE_HI: s_d.dec.op = ALD_UNSIGNED_WORD_DIVIDE;
                OP_UNSIGNED_WORD_MULTIPLY_HI: s_d.dec.op = ALD_UNSIGNED_WORD_MULTIPLY;
                OP_UNSIGNED_EXTENDED_DIVIDE_HI: s_d.dec.op = ALD_UNSIGNED_EXTENDED_DIVIDE;
                OP_SIGNED_WORD_MULTIPLY_HI: s_d.dec.op = ALD_SIGNED_WORD_MULTIPLY;
                default: begin
                  s_d.valid = 1'b0;
                  s_d.bad = 1'b1;
                end
              endcase
              s_d.dec.word = (b[7:3] != OP_UNSIGNED_BYTE_MULTIPLY_HI);
            end else begin
              // sfr prefix: second byte names op and form
              s_d.dec.op = ald_op_t'({1'b0, b[2:0]});
              s_d.dec.flags_only = (b[2:0] == 3'd7);
              s_d.need = 3'd3;
              if (b[7:3] == OP_B_SFR_IMM) begin
                s_d.dec.form = FRM_SFR_IMM;
                s_d.need = 3'd4;
              end else if (b[7:3] == OP_B_A_SFR) begin
                s_d.dec.form = FRM_SFR;
              end else if (b[7:3] == OP_W_SFRP_IMM ||
                           b[7:3] == OP_W_AX_SFRP) begin
                s_d.dec.word = 1'b1;
                s_d.dec.form = (b[7:3] == OP_W_SFRP_IMM) ?
                               FRM_SFR_IMM : FRM_SFR;
                s_d.need = (b[7:3] == OP_W_SFRP_IMM) ? 3'd5 : 3'd3;
                s_d.dec.op = b[1] ? (b[0] ? ALD_WORD_COMPARE :
                             ALD_WORD_SUBTRACT) : ALD_WORD_ADD;
                s_d.dec.flags_only = (b[1:0] == 2'd3);
              end else begin
                s_d.bad = 1'b1;
                s_d.st = ST_B1;
              end
            end
          end else begin
            case (s_q.dec.form)
              FRM_REG: begin
                s_d.dec.dst_reg = b[7:4];
                s_d.dec.src_reg = b[2:0];
                s_d.st = ST_B1;
                s_d.valid = ~b[3];
                if (b[3] && !b[4] && (s_q.b1 == OP_W_RR ||
                    s_q.b1 == 8'h8a || s_q.b1 == 8'h8f)) begin
                  s_d.valid = 1'b1;
                  s_d.dec.word = 1'b1;
                  s_d.dec.dst_reg = {1'b0, b[7:5]};
                  s_d.dec.op = s_q.b1[1] ? (s_q.b1[0] ? ALD_WORD_COMPARE :
                               ALD_WORD_SUBTRACT) : ALD_WORD_ADD;
                  s_d.dec.flags_only = (s_q.b1[1:0] == 2'd3);
                end
                s_d.bad = ~s_d.valid;
              end
              FRM_MEM: begin
                s_d.dec.mem = b[6:4];
                s_d.dec.mem_to_dest = b[7];
                s_d.dec.op = ald_op_t'({1'b0, b[2:0]});
                s_d.dec.flags_only = (b[2:0] == 3'd7);
                if (b[3:0] < OP_MEM_B_LOW) begin
                  s_d.bad = 1'b1;
                  s_d.st = ST_B1;
                end else if (s_q.need == 3'd2) begin
                  s_d.valid = 1'b1;
                  s_d.st = ST_B1;
                end
                if (s_q.dec.mod == MOD_INDEXED)
                  s_d.need = 3'd4;
              end
              FRM_IMM: begin
                s_d.dec.imm = {8'h00, b};
                if (s_q.need == 3'd2) begin
                  s_d.valid = 1'b1;
                  s_d.st = ST_B1;
                end
              end
              FRM_SADDR: begin
                s_d.dec.src_off = b;
                s_d.valid = 1'b1;
                s_d.st = ST_B1;
              end
              default: begin
                s_d.dec.src_off = b;
                s_d.dec.dst_off = b;
              end
            endcase
          end
        end
        ST_MORE: begin
          s_d.idx = s_q.idx + 3'd1;
          case (s_q.dec.form)
            FRM_MAC: s_d.dec.count = b;
            FRM_MEM: begin
              if (s_q.idx == 3'd2)
                s_d.dec.disp = {8'h00, b};
              else
                s_d.dec.disp[15:8] = b;
            end
            FRM_SADDR2: s_d.dec.dst_off = b;
            FRM_IMM: s_d.dec.imm[15:8] = b;
            FRM_SFR: s_d.dec.src_off = b;
            FRM_SADDR_IMM, FRM_SFR_IMM: begin
              if (s_q.pfx01 && s_q.idx == 3'd2)
                s_d.dec.dst_off = b;
              else if (s_q.idx + 3'd1 == s_q.need && s_q.dec.word)
                s_d.dec.imm[15:8] = b;
              else
                s_d.dec.imm[7:0] = b;
            end
            default: s_d.dec.imm[7:0] = b;
          endcase
          if (s_q.idx + 3'd1 >= s_q.need) begin
            s_d.valid = 1'b1;
            s_d.st = ST_B1;
          end
        end
        default: s_d.st = ST_B1;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.st <= ST_B1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_mac_count: assert property (
    s_q.st == ST_B2 && s_q.b1 == OP_PFX_07 && take && b == OP_MAC_B2
    ##1 take |=> dec_valid_out && dec_out.is_mac && !dec_out.mac_sat
      && dec_out.count == $past(byte_in))
    else $error("sum of products count not decoded");
  a_macs_sat: assert property (
    s_q.st == ST_B2 && s_q.b1 == OP_PFX_07 && take && b == OP_MACS_B2
    ##1 take |=> dec_valid_out && dec_out.mac_sat)
    else $error("saturating form not flagged");
  a_signed_word_multiply_pair: assert property (
    s_q.st == ST_B2 && s_q.b1 == OP_PFX_05 && take && b[7:3] == OP_SIGNED_WORD_MULTIPLY_HI
    |=> dec_valid_out && dec_out.op == ALD_SIGNED_WORD_MULTIPLY
      && dec_out.src_reg == $past(byte_in[2:0]))
    else $error("signed multiply misdecoded");
  a_unsigned_byte_multiply_op: assert property (
    s_q.st == ST_B2 && s_q.b1 == OP_PFX_05 && take && b[7:3] == OP_UNSIGNED_BYTE_MULTIPLY_HI
    |=> dec_valid_out && dec_out.op == ALD_UNSIGNED_BYTE_MULTIPLY)
    else $error("unsigned multiply misdecoded");
  a_rr_fields: assert property (
    s_q.st == ST_B1 && take && b[7:3] == OP_B_RR ##1 take && !b[3]
    |=> dec_valid_out && dec_out.dst_reg == $past(byte_in[7:4]))
    else $error("register fields misplaced");
  a_cmp_flags: assert property (
    dec_valid_out && !dec_out.word && !dec_out.is_mac &&
    dec_out.op == ALD_BYTE_COMPARE |-> dec_out.flags_only)
    else $error("compare writes a result");
  a_s2_order: assert property (
    s_q.st == ST_B1 && take && b[7:3] == OP_B_SADDR2 ##1 take ##1 take
    |=> dec_valid_out && dec_out.dst_off == $past(byte_in))
    else $error("destination offset order wrong");
  a_mem_dir: assert property (
    s_q.st == ST_B2 && !s_q.pfx01 && s_q.dec.form == FRM_MEM && take
    |=> dec_out.mem_to_dest == $past(byte_in[7]))
    else $error("memory direction bit lost");
  a_disp_high: assert property (
    dec_valid_out && dec_out.form == FRM_MEM && s_q.idx == 3'd4
    |-> dec_out.disp[15:8] == $past(byte_in))
    else $error("high displacement not fourth byte");

  c_mac: cover property (dec_valid_out && dec_out.is_mac);
  c_mem: cover property (dec_valid_out && dec_out.form == FRM_MEM);
  c_word: cover property (dec_valid_out && dec_out.word);
  c_bad: cover property (illegal_out);

endmodule

// File: hw/ald_pkg.sv
package ald_pkg;

  // ----------------------------------------------------------------
  // opcode constants
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PFX_01 = 8'h01;
  localparam logic [7:0] OP_PFX_05 = 8'h05;
  localparam logic [7:0] OP_PFX_07 = 8'h07;
  localparam logic [7:0] OP_MAC_B2 = 8'h85;
  localparam logic [7:0] OP_MACS_B2 = 8'h05;
  localparam logic [4:0] OP_SIGNED_WORD_MULTIPLY_HI = 5'h07;
  localparam logic [4:0] OP_UNSIGNED_BYTE_MULTIPLY_HI = 5'h01;
  localparam logic [4:0] OP_UNSIGNED_WORD_DIVIDE_HI = 5'h03;
  localparam logic [4:0] OP_UNSIGNED_WORD_MULTIPLY_HI = 5'h05;
  localparam logic [4:0] OP_UNSIGNED_EXTENDED_DIVIDE_HI = 5'h1d;
  // byte group upper five bits of first byte (of second byte after prefix 01 for sfr); memory top three and low four bits
  localparam logic [4:0] OP_B_IMM_A = 5'h15;
  localparam logic [4:0] OP_B_SADDR_IMM = 5'h0d;
  localparam logic [4:0] OP_B_RR = 5'h11;
  localparam logic [4:0] OP_B_A_SADDR = 5'h13;
  localparam logic [4:0] OP_B_SADDR2 = 5'h0f;
  localparam logic [4:0] OP_B_SFR_IMM = 5'h0d;
  localparam logic [4:0] OP_B_A_SFR = 5'h13;
  localparam logic [2:0] OP_MEM_TOP = 3'h0;
  localparam logic [3:0] OP_MEM_B_LOW = 4'h8;
  // word group first bytes; sfr pair codes are upper five bits of the byte after prefix 01
  localparam logic [7:0] OP_W_AX_IMM = 8'h2d;
  localparam logic [7:0] OP_W_SADDRP_IMM = 8'h0d;
  localparam logic [7:0] OP_W_RR = 8'h88;
  localparam logic [7:0] OP_W_AX_SADDRP = 8'h1d;
  localparam logic [7:0] OP_W_SADDRP2 = 8'h3d;
  localparam logic [4:0] OP_W_SFRP_IMM = 5'h01;
  localparam logic [4:0] OP_W_AX_SFRP = 5'h03;
  // mod codes with displacement
  localparam logic [4:0] MOD_BASED = 5'h06;
  localparam logic [4:0] MOD_INDEXED = 5'h0a;
  localparam logic [2:0] COUNT_RESET = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ALD_ADD, ALD_ADD_WITH_CARRY, ALD_SUB, ALD_SUBTRACT_WITH_BORROW,
    ALD_AND, ALD_XOR, ALD_OR, ALD_BYTE_COMPARE,
    ALD_WORD_ADD, ALD_WORD_SUBTRACT, ALD_WORD_COMPARE,
    ALD_UNSIGNED_BYTE_MULTIPLY, ALD_UNSIGNED_WORD_DIVIDE,
    ALD_UNSIGNED_WORD_MULTIPLY, ALD_UNSIGNED_EXTENDED_DIVIDE,
    ALD_SIGNED_WORD_MULTIPLY
  } ald_op_t;

  typedef enum logic [3:0] {
    FRM_IMM, FRM_REG, FRM_SADDR, FRM_SFR, FRM_MEM, FRM_SADDR2,
    FRM_SADDR_IMM, FRM_SFR_IMM, FRM_NONE, FRM_MAC
  } ald_form_t;

  typedef struct packed {
    ald_op_t op;
    ald_form_t form;
    logic is_mac;
    logic mac_sat;
    logic flags_only;
    logic word;
    logic mem_to_dest;
    logic [4:0] mod;
    logic [2:0] mem;
    logic [3:0] dst_reg;
    logic [2:0] src_reg;
    logic [7:0] src_off;
    logic [7:0] dst_off;
    logic [15:0] imm;
    logic [15:0] disp;
    logic [7:0] count;
  } ald_dec_t;

  typedef enum logic [1:0] {ST_B1, ST_B2, ST_MORE} ald_st_t;

  typedef struct packed {
    ald_st_t st;
    logic [2:0] idx;
    logic [2:0] need;
    logic pfx01;
    logic [7:0] b1;
    logic [7:0] b2;
    logic valid;
    logic bad;
    ald_dec_t dec;
  } ald_state_t;

endpackage

// File: testbench/ald_fetch_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// fetch side model: hands instruction bytes to the decoder
// ----------------------------------------------------------------
module ald_fetch_model (
  input wire logic sys_clk_in,
  input wire logic byte_ready_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out
);
  logic [7:0] last_byte;
  int stall_count;

  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
    last_byte = 8'h00;
    stall_count = 0;
  end

  // hold the byte until an edge samples ready high, bounded
  task automatic put(input logic [7:0] b);
    int n;
    byte_valid_out = 1'b1;
    byte_out = b;
    last_byte = b;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (byte_ready_in !== 1'b1 && n < 8);
    if (byte_ready_in !== 1'b1) begin
      stall_count++;
    end
    #1;
  endtask

  // released byte lane shows the inverse of the last byte
  task automatic idle();
    byte_valid_out = 1'b0;
    byte_out = ~last_byte;
    @(posedge sys_clk_in);
    #1;
  endtask
endmodule

// File: testbench/arith_logic_instr_decoder_bench.sv
`timescale 1ns/1ps

module arith_logic_instr_decoder_bench;
  import ald_pkg::*;

  logic sys_clk_in;
  logic rst_n_in;
  logic byte_valid;
  logic [7:0] byte_w;
  logic byte_ready;
  logic dec_valid;
  logic illegal;
  ald_dec_t dec;
  int num_errors = 0;
  int cmp_count = 0;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  ald_decoder u_ald_decoder (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .byte_valid_in(byte_valid), .byte_in(byte_w),
    .byte_ready_out(byte_ready), .dec_valid_out(dec_valid),
    .dec_out(dec), .illegal_out(illegal)
  );

  ald_fetch_model u_ald_fetch_model (
    .sys_clk_in(sys_clk_in), .byte_ready_in(byte_ready),
    .byte_valid_out(byte_valid), .byte_out(byte_w)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk_bit(input logic got, input logic exp, input string w);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, w, got, exp);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                         input string w);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic feed(input logic [7:0] q[$]);
    foreach (q[i]) u_ald_fetch_model.put(q[i]);
  endtask

  // outputs of the edge that took the last byte
  task automatic done(input logic ok);
    chk_bit(dec_valid, ok, "dec valid");
    chk_bit(illegal, ~ok, "illegal");
    chk_bit(byte_ready, 1'b1, "ready");
    u_ald_fetch_model.idle();
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_byte_ops();
    for (int k = 0; k < 8; k++) begin
      feed('{{5'h11, 3'(k)}, 8'ha3});
      done(1'b1);
      chk_val(16'(dec.op), 16'(k), "op");
      chk_val(16'(dec.form), 16'(FRM_REG), "form");
      chk_val(16'(dec.dst_reg), 16'h000a, "dst");
      chk_val(16'(dec.src_reg), 16'h0003, "src");
      chk_bit(dec.flags_only, k == 7, "flags only");
    end
    feed('{8'h88, 8'h18});
    done(1'b0);
    feed('{8'haf, 8'h5c});
    done(1'b1);
    chk_val(16'(dec.op), 16'(ALD_BYTE_COMPARE), "imm op");
    chk_val(16'(dec.imm[7:0]), 16'h005c, "imm");
    $display("test byte_ops done");
  endtask

  task automatic t_word_ops();
    for (int j = 0; j < 3; j++) begin
      feed('{8'h2d + 8'(j), 8'h34, 8'h12});
      done(1'b1);
      chk_val(16'(dec.op), 16'(ALD_WORD_ADD) + 16'(j), "wop");
      chk_val(dec.imm, 16'h1234, "word imm");
      chk_bit(dec.word, 1'b1, "word");
    end
    feed('{8'h88, 8'h4e});
    done(1'b1);
    chk_val(16'(dec.op), 16'(ALD_WORD_ADD), "pair op");
    chk_bit(dec.word, 1'b1, "pair word");
    chk_val(16'(dec.dst_reg), 16'h0002, "pair dst");
    chk_val(16'(dec.src_reg), 16'h0006, "pair src");
    feed('{8'h8f, 8'ha9});
    done(1'b1);
    chk_val(16'(dec.op), 16'(ALD_WORD_COMPARE), "pair cmp");
    chk_bit(dec.flags_only, 1'b1, "pair flags");
    feed('{8'h01, 8'h0d, 8'h40, 8'h34, 8'h12});
    done(1'b1);
    chk_val(16'(dec.form), 16'(FRM_SFR_IMM), "sfrp form");
    chk_val(16'(dec.dst_off), 16'h0040, "sfrp off");
    chk_val(dec.imm, 16'h1234, "sfrp imm");
    feed('{8'h01, 8'h1e, 8'h55});
    done(1'b1);
    chk_val(16'(dec.op), 16'(ALD_WORD_SUBTRACT), "sfrp op");
    chk_val(16'(dec.src_off), 16'h0055, "sfrp src");
    feed('{8'h3d, 8'h10, 8'h20});
    done(1'b1);
    chk_val(16'(dec.src_off), 16'h0010, "src off");
    chk_val(16'(dec.dst_off), 16'h0020, "dst off");
    $display("test word_ops done");
  endtask

  task automatic t_muldiv();
    logic [4:0] hi[4] = '{5'h01, 5'h03, 5'h05, 5'h1d};
    ald_op_t op[4] = '{ALD_UNSIGNED_BYTE_MULTIPLY,
      ALD_UNSIGNED_WORD_DIVIDE, ALD_UNSIGNED_WORD_MULTIPLY,
      ALD_UNSIGNED_EXTENDED_DIVIDE};
    for (int i = 0; i < 4; i++) begin
      feed('{8'h05, {hi[i], 3'h6}});
      done(1'b1);
      chk_val(16'(dec.op), 16'(op[i]), "muldiv op");
    end
    feed('{8'h05, 8'h3a});
    done(1'b1);
    chk_val(16'(dec.op), 16'(ALD_SIGNED_WORD_MULTIPLY), "signed_word_multiply");
    $display("test muldiv done");
  endtask

  task automatic t_mac(input logic [7:0] b2, input logic [7:0] n,
                       input logic sat);
    feed('{8'h07, b2});
    chk_bit(dec_valid, 1'b0, "mac early");
    feed('{n});
    done(1'b1);
    chk_bit(dec.is_mac, 1'b1, "is mac");
    chk_bit(dec.mac_sat, sat, "sat");
    chk_val(16'(dec.count), 16'(n), "count");
    $display("test mac done");
  endtask

  task automatic t_mem();
    feed('{8'h06, 8'h28, 8'h5a});
    done(1'b1);
    chk_val(16'(dec.form), 16'(FRM_MEM), "mem form");
    chk_val(16'(dec.mod), 16'h0006, "mod");
    chk_val(16'(dec.mem), 16'h0002, "mem");
    chk_bit(dec.mem_to_dest, 1'b0, "dir acc");
    chk_val(16'(dec.disp[7:0]), 16'h005a, "disp lo");
    feed('{8'h0a, 8'h9f, 8'h34});
    chk_bit(dec_valid, 1'b0, "mem early");
    feed('{8'h12});
    done(1'b1);
    chk_val(dec.disp, 16'h1234, "disp16");
    chk_bit(dec.mem_to_dest, 1'b1, "dir mem");
    chk_val(16'(dec.op), 16'(ALD_BYTE_COMPARE), "mem op");
    $display("test mem done");
  endtask

  task automatic t_short();
    feed('{8'h9c, 8'h05});
    done(1'b1);
    chk_val(16'(dec.form), 16'(FRM_SADDR), "short form");
    feed('{8'h01, 8'h9c, 8'h25});
    done(1'b1);
    chk_val(16'(dec.form), 16'(FRM_SFR), "sfr form");
    feed('{8'h78, 8'h20, 8'h30});
    done(1'b1);
    chk_val(16'(dec.src_off), 16'h0020, "src off");
    chk_val(16'(dec.dst_off), 16'h0030, "dst off");
    $display("test short done");
  endtask

  task automatic t_reset_mid();
    feed('{8'h07});
    u_ald_fetch_model.idle();
    rst_n_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk_bit(dec_valid, 1'b0, "reset valid");
    chk_val(16'(dec.op), 16'h0000, "reset dec");
    rst_n_in = 1'b1;
    feed('{8'h8a, 8'h51});
    done(1'b1);
    chk_val(16'(dec.op), 16'(ALD_SUB), "after reset");
    $display("test reset_mid done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1;
    chk_bit(dec_valid, 1'b0, "idle valid");
    chk_bit(illegal, 1'b0, "idle illegal");
    rst_n_in = 1'b1;
    t_byte_ops();
    t_word_ops();
    t_muldiv();
    t_mac(8'h85, 8'hff, 1'b0);
    t_mac(8'h05, 8'h00, 1'b1);
    t_mem();
    t_short();
    t_reset_mid();
    chk_val(16'(u_ald_fetch_model.stall_count), 16'h0000, "stalls");
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    $display("MISMATCH t=%0t run did not end", $time);
    wrap_up();
  end
endmodule
